// ---- src/sat_unit_pkg.sv ----
// Purpose: shared constants for the saturating multiply and pack datapath
// Assumes: single 125 MHz core clock
// Notes:   opcodes are local codes for the issue port
package sat_unit_pkg;
    localparam int          WORD_W       = 32;
    localparam int          HALF_W       = 16;
    localparam int          MUL_STAGES   = 4;
    localparam int          SAT_LAG      = 1;
    localparam int          OP_W         = 2;
    localparam logic [1:0]  OP_DUAL_MUL  = 2'h0;
    localparam logic [1:0]  OP_WIDE_MUL  = 2'h1;
    localparam logic [1:0]  OP_SPACK     = 2'h2;
    localparam logic [1:0]  OP_BPACK     = 2'h3;
    localparam logic [31:0] WORD_MIN     = 32'h8000_0000;
    localparam logic [31:0] WORD_MAX     = 32'h7FFF_FFFF;
    localparam logic [15:0] HALF_MIN     = 16'h8000;
    localparam logic [15:0] HALF_MAX     = 16'h7FFF;
    localparam logic [7:0]  BYTE_MAX     = 8'hFF;
    localparam logic [7:0]  BYTE_MIN     = 8'h00;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
endpackage : sat_unit_pkg

// ---- src/pack_saturator.sv ----
// Purpose: combinational saturating pack of two words
// Assumes: operands stable for the issue cycle
// Notes:   neither pack reports saturation by design
`timescale 1ns/1ps
module pack_saturator (
    input  wire logic        byte_mode,
    input  wire logic [31:0] src_a,
    input  wire logic [31:0] src_b,
    output logic      [31:0] result
);
    logic [15:0] half_a;
    logic [15:0] half_b;
    logic [63:0] halves;
    logic [31:0] byte_word;

    // signed 32 to signed 16 clamp
    function automatic logic [15:0] clamp16(input logic [31:0] v);
        logic signed [31:0] s;
        s = v;
        if (s > $signed({{16{1'b0}}, sat_unit_pkg::HALF_MAX}))
            clamp16 = sat_unit_pkg::HALF_MAX;
        else if (s < $signed({{16{1'b1}}, sat_unit_pkg::HALF_MIN}))
            clamp16 = sat_unit_pkg::HALF_MIN;
        else
            clamp16 = v[15:0];
    endfunction : clamp16

    assign half_a = clamp16(src_a);
    assign half_b = clamp16(src_b);
    assign halves = {src_a, src_b};

    // byte lane k takes halfword k: upper of src_a lands in the top byte
    for (genvar k = 0; k < 4; k++) begin : g_lane
        wire logic [15:0] h = halves[16*k +: 16];
        assign byte_word[8*k +: 8] = h[15] ? sat_unit_pkg::BYTE_MIN :
                                     (|h[14:8]) ? sat_unit_pkg::BYTE_MAX :
                                     h[7:0];
    end

    assign result = byte_mode ? byte_word : {half_a, half_b};
endmodule : pack_saturator

// ---- src/saturating_multiply_pack_unit.sv ----
// Purpose: four-stage saturating multiplies and single-cycle saturating packs
// Assumes: issue never overlaps two multiplies on one unit faster than one per cycle
// Notes:   flags are one-cycle pulses the status logic ORs into its sticky bits
`timescale 1ns/1ps
// Functional notes
// - dual products shifted, min pattern becomes max
// - low product to even, high to odd
// - saturation flag pulses after pair write
// - dual multiply writes result in fourth stage
// - wide multiply returns upper shifted word
// - wide saturation sets unit bit and flag
// - wide multiply ignores condition entirely
// - min times min yields max word
// - signed pack: first upper, second lower
// - each input clamped to signed 16
// - packs never touch saturation flag
// - signed pack completes in one cycle
// - byte pack halfword to byte mapping
// - byte pack clamps to 0..255
module saturating_multiply_pack_unit #(
    parameter int UNIT_ID = 0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        issue,
    input  wire logic [1:0]  opcode,
    input  wire logic        cond_true,
    input  wire logic [31:0] src1,
    input  wire logic [31:0] src2,
    output logic             pack_write,
    output logic [31:0]      pack_data,
    output logic             mul_write,
    output logic             mul_pair,
    output logic [31:0]      mul_even,
    output logic [31:0]      mul_odd,
    output logic             csr_sat_set,
    output logic             ssr_unit1_set,
    output logic             ssr_unit2_set
);
    initial begin
        if (UNIT_ID < 0 || UNIT_ID > 1)
            $error("UNIT_ID must be 0 or 1");
    end

    localparam int LAST = sat_unit_pkg::MUL_STAGES - 1;

    // decode
    wire logic is_dual  = issue && opcode == sat_unit_pkg::OP_DUAL_MUL && cond_true;
    wire logic is_wide  = issue && opcode == sat_unit_pkg::OP_WIDE_MUL;
    wire logic is_pack  = issue && (opcode == sat_unit_pkg::OP_SPACK ||
                                    opcode == sat_unit_pkg::OP_BPACK) && cond_true;
    wire logic byte_mode = opcode == sat_unit_pkg::OP_BPACK;

    // stage one: products computed from operands read at issue
    wire logic signed [31:0] lo_prod   = $signed(src1[15:0]) * $signed(src2[15:0]);
    wire logic signed [31:0] hi_prod   = $signed(src1[31:16]) * $signed(src2[31:16]);
    wire logic        [31:0] lo_shift  = {lo_prod[30:0], 1'b0};
    wire logic        [31:0] hi_shift  = {hi_prod[30:0], 1'b0};
    wire logic               lo_sat    = lo_shift == sat_unit_pkg::WORD_MIN;
    wire logic               hi_sat    = hi_shift == sat_unit_pkg::WORD_MIN;
    wire logic        [31:0] lo_res    = lo_sat ? sat_unit_pkg::WORD_MAX : lo_shift;
    wire logic        [31:0] hi_res    = hi_sat ? sat_unit_pkg::WORD_MAX : hi_shift;

    wire logic signed [63:0] wide_prod = $signed(src1) * $signed(src2);
    // shift overflows only when the top two bits differ; only min*min gets there
    wire logic               wide_sat  = wide_prod[63] != wide_prod[62];
    wire logic        [31:0] wide_res  = wide_sat ? sat_unit_pkg::WORD_MAX : wide_prod[62:31];

    wire logic [31:0] next_even = is_wide ? wide_res : lo_res;
    wire logic [31:0] next_odd  = is_wide ? sat_unit_pkg::RESET_WORD : hi_res;
    wire logic        next_sat  = is_wide ? wide_sat : (lo_sat | hi_sat);

    logic [31:0] pack_result;

    pack_saturator u_pack (
        .byte_mode (byte_mode),
        .src_a     (src1),
        .src_b     (src2),
        .result    (pack_result)
    );

    // pipeline of stages two to four; operands are not held, only results
    logic [LAST-1:0] v_pipe;
    logic [LAST-1:0] pair_pipe;
    logic [LAST-1:0] sat_pipe;
    logic [31:0]     even_pipe [LAST];
    logic [31:0]     odd_pipe  [LAST];
    logic            sat_late;
    logic            wide_late;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            v_pipe    <= '0;
            pair_pipe <= '0;
            sat_pipe  <= '0;
        end else begin
            v_pipe    <= {v_pipe[LAST-2:0], is_dual | is_wide};
            pair_pipe <= {pair_pipe[LAST-2:0], is_dual};
            sat_pipe  <= {sat_pipe[LAST-2:0], next_sat};
        end
    end

    always_ff @(posedge clk) begin
        even_pipe[0] <= next_even;
        odd_pipe[0]  <= next_odd;
        for (int i = 1; i < LAST; i++) begin
            even_pipe[i] <= even_pipe[i-1];
            odd_pipe[i]  <= odd_pipe[i-1];
        end
    end

    // result registered out at the end of stage four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mul_write <= 1'b0;
            mul_pair  <= 1'b0;
            mul_even  <= sat_unit_pkg::RESET_WORD;
            mul_odd   <= sat_unit_pkg::RESET_WORD;
            sat_late  <= 1'b0;
            wide_late <= 1'b0;
        end else begin
            mul_write <= v_pipe[LAST-1];
            mul_pair  <= pair_pipe[LAST-1];
            mul_even  <= even_pipe[LAST-1];
            mul_odd   <= odd_pipe[LAST-1];
            sat_late  <= v_pipe[LAST-1] & sat_pipe[LAST-1];
            wide_late <= v_pipe[LAST-1] & ~pair_pipe[LAST-1];
        end
    end

    // flags one cycle after the write; packs never reach them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_sat_set   <= 1'b0;
            ssr_unit1_set <= 1'b0;
            ssr_unit2_set <= 1'b0;
        end else begin
            csr_sat_set   <= sat_late;
            ssr_unit1_set <= sat_late & wide_late & (UNIT_ID == 0);
            ssr_unit2_set <= sat_late & wide_late & (UNIT_ID == 1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pack_write <= 1'b0;
            pack_data  <= sat_unit_pkg::RESET_WORD;
        end else begin
            pack_write <= is_pack;
            if (is_pack)
                pack_data <= pack_result;
        end
    end

    a_dual_latency: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual |-> ##4 (mul_write && mul_pair)) else $error("dual result not written in stage four");
    a_wide_latency: assert property (@(posedge clk) disable iff (!rst_n)
        is_wide |-> ##4 (mul_write && !mul_pair)) else $error("wide result not written in stage four");
    a_wide_uncond: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && opcode == sat_unit_pkg::OP_WIDE_MUL && !cond_true) |-> ##4 mul_write)
        else $error("wide multiply was predicated");
    a_minmin_max: assert property (@(posedge clk) disable iff (!rst_n)
        (is_wide && src1 == sat_unit_pkg::WORD_MIN && src2 == sat_unit_pkg::WORD_MIN)
        |-> ##4 mul_even == sat_unit_pkg::WORD_MAX) else $error("min times min not saturated");
    a_sat_after: assert property (@(posedge clk) disable iff (!rst_n)
        (is_dual && (lo_sat || hi_sat)) |-> ##5 csr_sat_set) else $error("saturation flag late or missing");
    a_wide_unit: assert property (@(posedge clk) disable iff (!rst_n)
        (is_wide && wide_sat) |-> ##5 (ssr_unit1_set || ssr_unit2_set) && csr_sat_set)
        else $error("unit saturation bit missing");
    a_pack_noflag: assert property (@(posedge clk) disable iff (!rst_n)
        csr_sat_set |-> $past(mul_write)) else $error("flag without multiply");
    a_false_nop: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && !cond_true && opcode != sat_unit_pkg::OP_WIDE_MUL && !v_pipe[0] && !v_pipe[1] && !v_pipe[2])
        |=> !pack_write) else $error("false condition produced a write");
    a_pack_one: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack |=> pack_write && pack_data == $past(pack_result)) else $error("pack not single cycle");
    a_dual_order: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual |-> ##4 (mul_even == $past(lo_res, 4) && mul_odd == $past(hi_res, 4)))
        else $error("dual halves swapped");

    // multiply checks against independent values, except the two saturation checks, which key on the datapath's own lo_sat and hi_sat
    a_dual_lo_sat: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual && lo_sat
        |-> ##4 mul_even == sat_unit_pkg::WORD_MAX)
        else $error("low product not saturated");

    a_dual_hi_sat: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual && hi_sat
        |-> ##4 mul_odd == sat_unit_pkg::WORD_MAX)
        else $error("high product not saturated");

    a_dual_minmin: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual && src1[15:0] == sat_unit_pkg::HALF_MIN && src2[15:0] == sat_unit_pkg::HALF_MIN
        |-> ##4 mul_even == sat_unit_pkg::WORD_MAX)
        else $error("low min times min not clamped");

    a_dual_hminmin: assert property (@(posedge clk) disable iff (!rst_n)
        is_dual && src1[31:16] == sat_unit_pkg::HALF_MIN && src2[31:16] == sat_unit_pkg::HALF_MIN
        |-> ##4 mul_odd == sat_unit_pkg::WORD_MAX)
        else $error("high min times min not in odd word");

    a_wide_odd_zero: assert property (@(posedge clk) disable iff (!rst_n)
        is_wide
        |-> ##4 mul_odd == sat_unit_pkg::RESET_WORD)
        else $error("wide multiply left odd word dirty");

    a_wide_one: assert property (@(posedge clk) disable iff (!rst_n)
        is_wide && src2 == 32'h0000_0001
        |-> ##4 mul_even == {32{$past(src1[31], 4)}})
        else $error("wide upper word wrong for unit factor");

    a_wide_zero: assert property (@(posedge clk) disable iff (!rst_n)
        is_wide && src1 == 32'h0000_0000
        |-> ##4 mul_even == 32'h0000_0000)
        else $error("wide product of zero not zero");

    a_unit1_match: assert property (@(posedge clk) disable iff (!rst_n)
        ssr_unit1_set
        |-> UNIT_ID == 0)
        else $error("unit one bit from wrong unit");

    a_unit2_match: assert property (@(posedge clk) disable iff (!rst_n)
        ssr_unit2_set
        |-> UNIT_ID == 1)
        else $error("unit two bit from wrong unit");

    a_unit_with_csr: assert property (@(posedge clk) disable iff (!rst_n)
        ssr_unit1_set || ssr_unit2_set
        |-> csr_sat_set)
        else $error("unit bit without status flag");

    a_unit_wide_only: assert property (@(posedge clk) disable iff (!rst_n)
        ssr_unit1_set || ssr_unit2_set
        |-> $past(mul_write && !mul_pair))
        else $error("unit bit not after wide write");

    a_write_issued: assert property (@(posedge clk) disable iff (!rst_n)
        mul_write
        |-> $past(issue, 4))
        else $error("multiply write without issue four cycles back");

    a_write_op: assert property (@(posedge clk) disable iff (!rst_n)
        mul_write
        |-> !$past(opcode[1], 4))
        else $error("multiply write from a pack");

    a_pair_dual: assert property (@(posedge clk) disable iff (!rst_n)
        mul_write && mul_pair
        |-> $past(opcode, 4) == sat_unit_pkg::OP_DUAL_MUL)
        else $error("pair write not from dual multiply");

    a_pair_wide: assert property (@(posedge clk) disable iff (!rst_n)
        mul_write && !mul_pair
        |-> $past(opcode, 4) == sat_unit_pkg::OP_WIDE_MUL)
        else $error("single write not from wide multiply");

    a_dual_cond: assert property (@(posedge clk) disable iff (!rst_n)
        mul_write && mul_pair
        |-> $past(cond_true, 4))
        else $error("dual multiply ran with false condition");

    a_flag_mult: assert property (@(posedge clk) disable iff (!rst_n)
        csr_sat_set
        |-> $past(issue, 5) && !$past(opcode[1], 5))
        else $error("status flag traced to a pack");

    // pack checks
    a_pack_cond: assert property (@(posedge clk) disable iff (!rst_n)
        pack_write
        |-> $past(issue && cond_true))
        else $error("pack written with false condition");

    a_pack_op: assert property (@(posedge clk) disable iff (!rst_n)
        pack_write
        |-> $past(opcode[1]))
        else $error("pack write from a multiply");

    a_pack_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !is_pack
        |=> $stable(pack_data))
        else $error("pack data changed without a pack");

    a_spack_hi_max: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && !byte_mode && $signed(src1) > 32'sh0000_7FFF
        |=> pack_data[31:16] == sat_unit_pkg::HALF_MAX)
        else $error("signed pack upper not clamped high");

    a_spack_hi_min: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && !byte_mode && $signed(src1) < 32'shFFFF_8000
        |=> pack_data[31:16] == sat_unit_pkg::HALF_MIN)
        else $error("signed pack upper not clamped low");

    a_spack_lo_pass: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && !byte_mode && (src2[31:15] == 17'h0_0000 || src2[31:15] == 17'h1_FFFF)
        |=> pack_data[15:0] == $past(src2[15:0]))
        else $error("signed pack lower half wrong");

    a_spack_hi_pass: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && !byte_mode && (src1[31:15] == 17'h0_0000 || src1[31:15] == 17'h1_FFFF)
        |=> pack_data[31:16] == $past(src1[15:0]))
        else $error("signed pack upper half wrong");

    a_bpack_neg: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && byte_mode && src1[31]
        |=> pack_data[31:24] == sat_unit_pkg::BYTE_MIN)
        else $error("negative halfword not cleared");

    a_bpack_over: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && byte_mode && !src2[15] && src2[14:8] != 7'h00
        |=> pack_data[7:0] == sat_unit_pkg::BYTE_MAX)
        else $error("large halfword not forced to ones");

    a_bpack_mid: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && byte_mode && src1[15:8] == 8'h00
        |=> pack_data[23:16] == $past(src1[7:0]))
        else $error("byte two not from low half of first source");

    a_bpack_b1: assert property (@(posedge clk) disable iff (!rst_n)
        is_pack && byte_mode && src2[31:24] == 8'h00
        |=> pack_data[15:8] == $past(src2[23:16]))
        else $error("byte one not from high half of second source");

    c_dual_sat: cover property (@(posedge clk) disable iff (!rst_n) is_dual && lo_sat);
    c_wide_sat: cover property (@(posedge clk) disable iff (!rst_n) is_wide && wide_sat);
    c_byte_pack: cover property (@(posedge clk) disable iff (!rst_n) is_pack && byte_mode);
    c_back2back: cover property (@(posedge clk) disable iff (!rst_n) is_dual ##1 is_wide);
    c_false_pack: cover property (@(posedge clk) disable iff (!rst_n) issue && !cond_true && opcode[1]);
endmodule : saturating_multiply_pack_unit

// ---- tb/status_regfile_model.sv ----
// Purpose: far side model, destination registers and sticky status bits
// Assumes: write and flag inputs are one-cycle pulses
// Notes:   sticky bits clear only on reset, so a stray pulse is never lost
`timescale 1ns/1ps
module status_regfile_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pack_write,
    input  wire logic [31:0] pack_data,
    input  wire logic        mul_write,
    input  wire logic [31:0] mul_even,
    input  wire logic [31:0] mul_odd,
    input  wire logic        csr_sat_set,
    output logic      [63:0] last_mul,
    output logic      [31:0] last_pack,
    output logic             sat_sticky
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_mul   <= 64'h0000_0000_0000_0000;
            last_pack  <= 32'h0000_0000;
            sat_sticky <= 1'h0;
        end else begin
            if (mul_write) last_mul <= {mul_odd, mul_even};
            if (pack_write) last_pack <= pack_data;
            sat_sticky <= sat_sticky | csr_sat_set;
        end
    end
endmodule : status_regfile_model

// ---- tb/test_saturating_multiply_pack_unit.sv ----
// Purpose: corner and random tests of the saturating multiply and pack unit
// Assumes: one instruction in flight at a time, unit 0
// Notes:   results are checked through the register file model
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_saturating_multiply_pack_unit;
    logic        clk, rst_n, issue, cond_true, pack_write, mul_write, mul_pair;
    logic        csr_sat_set, ssr_unit1_set, ssr_unit2_set, sat_sticky, exp_sticky;
    logic [1:0]  opcode;
    logic [31:0] src1, src2, pack_data, mul_even, mul_odd, last_pack, seed, a;
    logic [63:0] last_mul;
    int          bad_count, cmp_count;
    saturating_multiply_pack_unit #(.UNIT_ID(0)) saturating_multiply_pack_unit_i (.clk(clk), .rst_n(rst_n),
        .issue(issue), .opcode(opcode), .cond_true(cond_true), .src1(src1), .src2(src2), .pack_write(pack_write),
        .pack_data(pack_data), .mul_write(mul_write), .mul_pair(mul_pair), .mul_even(mul_even), .mul_odd(mul_odd),
        .csr_sat_set(csr_sat_set), .ssr_unit1_set(ssr_unit1_set), .ssr_unit2_set(ssr_unit2_set));
    status_regfile_model status_regfile_model_i (.clk(clk), .rst_n(rst_n), .pack_write(pack_write),
        .pack_data(pack_data), .mul_write(mul_write), .mul_even(mul_even), .mul_odd(mul_odd),
        .csr_sat_set(csr_sat_set), .last_mul(last_mul), .last_pack(last_pack), .sat_sticky(sat_sticky));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [32:0] sm16(logic [15:0] x, logic [15:0] y);
        logic signed [31:0] p;
        p = ($signed(x) * $signed(y)) <<< 1;
        return (p === 32'sh8000_0000) ? {1'h1, sat_unit_pkg::WORD_MAX} : {1'h0, p};
    endfunction : sm16
    function automatic logic [32:0] sm32(logic [31:0] x, logic [31:0] y);
        logic signed [63:0] p;
        p = $signed(x) * $signed(y);
        // only min times min can overflow the shift, and that is positive
        return (p[63] ^ p[62]) ? {1'h1, sat_unit_pkg::WORD_MAX} : {1'h0, p[62:31]};
    endfunction : sm32
    function automatic logic [15:0] s16(logic [31:0] v);
        return ($signed(v) > 32767) ? sat_unit_pkg::HALF_MAX : ($signed(v) < -32768) ? sat_unit_pkg::HALF_MIN : v[15:0];
    endfunction : s16
    function automatic logic [7:0] u8(logic [15:0] v);
        return v[15] ? sat_unit_pkg::BYTE_MIN : (v > 16'h00FF) ? sat_unit_pkg::BYTE_MAX : v[7:0];
    endfunction : u8
    function automatic logic [64:0] expect_op(logic [1:0] op, logic [31:0] x, logic [31:0] y);
        logic [32:0] lo, hi, w;
        lo = sm16(x[15:0], y[15:0]);
        hi = sm16(x[31:16], y[31:16]);
        w = sm32(x, y);
        case (op)
            sat_unit_pkg::OP_DUAL_MUL: return {lo[32] | hi[32], hi[31:0], lo[31:0]};
            sat_unit_pkg::OP_WIDE_MUL: return {w[32], 32'h0000_0000, w[31:0]};
            sat_unit_pkg::OP_SPACK:    return {33'h0_0000_0000, s16(x), s16(y)};
            default:                   return {33'h0_0000_0000, u8(x[31:16]), u8(x[15:0]), u8(y[31:16]), u8(y[15:0])};
        endcase
    endfunction : expect_op
    task automatic run(input logic [1:0] op, input logic c, input logic [31:0] x, input logic [31:0] y);
        logic [64:0] e;
        logic [95:0] prev;
        logic        live, mul, pair;
        int          wr_at, sat_at, ssr_at, stray;
        e = expect_op(op, x, y);
        mul = !op[1];
        live = c || (op == sat_unit_pkg::OP_WIDE_MUL);
        wr_at = 0;
        sat_at = 0;
        ssr_at = 0;
        stray = 0;
        prev = {last_mul, last_pack};
        @(posedge clk);
        issue <= 1'h1;
        opcode <= op;
        cond_true <= c;
        src1 <= x;
        src2 <= y;
        for (int k = 1; k <= 7; k++) begin
            @(posedge clk);
            if (k == 1)
                issue <= 1'h0;
            #1;
            if ((mul ? mul_write : pack_write) && wr_at == 0) begin
                wr_at = k;
                pair = mul_pair;
            end
            if ((mul ? pack_write : mul_write) || ssr_unit2_set) stray++;
            if (csr_sat_set) sat_at = k;
            if (ssr_unit1_set) ssr_at = k;
        end
        exp_sticky = exp_sticky | (live & mul & e[64]);
        `CHK("write cycle", live ? (mul ? 4 : 1) : 0, wr_at)
        `CHK("stray pulse", 0, stray)
        `CHK("sat cycle", (live && mul && e[64]) ? 5 : 0, sat_at)
        `CHK("unit bit cycle", (op == sat_unit_pkg::OP_WIDE_MUL && e[64]) ? 5 : 0, ssr_at)
        `CHK("sticky sat", exp_sticky, sat_sticky)
        if (!live) `CHK("held data", prev, {last_mul, last_pack})
        if (live && mul) `CHK("pair flag", !op[0], pair)
        if (live && mul) `CHK("product", e[63:0], last_mul)
        if (live && !mul) `CHK("pack data", e[31:0], last_pack)
        $display("test op %0d cond %0d done", op, c);
    endtask : run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst_n, issue, opcode, cond_true, src1, src2, exp_sticky, bad_count, cmp_count} = '0;
        seed = 32'h0000_005A;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        run(2'h0, 1'h1, 32'h6A32_1193, 32'hB174_6CA4);
        run(2'h0, 1'h0, 32'h8000_8000, 32'h8000_8000);
        run(2'h1, 1'h1, 32'h8765_4321, 32'h1234_5678);
        run(2'h2, 1'h1, 32'hFFFF_8000, 32'h0000_7FFF);
        run(2'h2, 1'h1, 32'hFFFF_7FFF, 32'h0000_8000);
        run(2'h3, 1'h1, 32'h00FF_0100, 32'hFFFF_0000);
        run(2'h3, 1'h0, 32'h1234_5678, 32'h0011_0022);
        run(2'h0, 1'h1, 32'h1234_8000, 32'h7FFF_8000);
        run(2'h1, 1'h0, 32'h8000_0000, 32'h8000_0000);
        run(2'h0, 1'h1, 32'h8000_0001, 32'h8000_0001);
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            a = seed;
            seed = lfsr(seed);
            run(a[1:0], a[2] | a[3], a, seed);
        end
        end_of_test();
    end
endmodule : test_saturating_multiply_pack_unit
